// [test_uart_control_word_zero.sv]
// Purpose: self-checking bench for the control word zero block
// Assumes: zero wait state AHB-Lite slave, partner makes ticks and frames
// Notes: expectations come from a behavioural model of the register
`timescale 1ns/1ps
`default_nettype none
`include "ucw_params.svh"
module test_uart_control_word_zero;
    import ucw_pkg::*;
    // bus and clocking
    logic clk, srst, hsel, hwrite, hreadyout, hresp, rxCharValid, kernelClkSlow, frameGo;
    logic [31:0] haddr, hwdata, hrdata, rdv, ctlM, rnd;
    logic [1:0] htrans;
    logic [8:0] rxChar;
    logic [7:0] flags, matchVal;
    // block outputs and partner wires
    logic sampleRateSelect, frameSizeSelect, muteSelect, muteWakeMethod, parityOn;
    logic parityOddSelect, txOn, rxOn, blockOn, lineDriverEnable, startGo, irqOut, wakeReq;
    logic sampleTick, txFrameReq, txMsgEnd, frameDone, matchM, goSeen, endSeen;
    int errTotal, totalChecks, leadCnt, tailCnt, n;
    int irqPos[8] = '{27, 26, 8, 7, 6, 5, 5, 4}; // enable bit of each flag
    logic [4:0] leadTab[3] = '{5'h01, 5'h1f, 5'h05};
    logic [4:0] tailTab[3] = '{5'h01, 5'h1f, 5'h02};
    ucw_control_word_zero dut (.clk, .srst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .blockEndFlag(flags[0]), .rxTimeoutFlag(flags[1]), .parityFaultFlag(flags[2]),
        .txEmptyFlag(flags[3]), .txDoneFlag(flags[4]), .rxReadyFlag(flags[5]),
        .overrunFlag(flags[6]), .idleLineFlag(flags[7]), .rxCharValid, .rxChar,
        .sampleTick, .kernelClkSlow, .txFrameReq, .txMsgEnd, .sampleRateSelect,
        .frameSizeSelect, .muteSelect, .muteWakeMethod, .parityOn, .parityOddSelect,
        .txOn, .rxOn, .blockOn, .lineDriverEnable, .startGo, .irqOut, .wakeReq);
    ucw_line_partner partner (.clk, .srst, .frameGo, .frameDone, .startGo,
        .sampleTick, .txFrameReq, .txMsgEnd);
    // ----------------------------------------
    // model and helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // next control value: format fields hold while the block is on
    function automatic logic [31:0] ctl_next(input logic [31:0] o, input logic [31:0] w);
        logic [31:0] v;
        v = o[0] ? ((o & `UCW_LOCK_MASK) | (w & ~`UCW_LOCK_MASK)) : w;
        return v & `UCW_VALID_FULL;
    endfunction
    // one request line from all enabled events
    function automatic logic irq_model(input logic [7:0] f, input logic [31:0] c);
        logic r;
        r = matchM & c[14];
        for (int j = 0; j < 8; j++) r |= f[j] & c[irqPos[j]];
        return r;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // single word transfer, address phase then data phase
    task automatic bus_xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdv = hrdata;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus_xfer(a, 1'b0, 32'h00000000);
        chk(rdv, exp);
    endtask
    task automatic wr_ctl(input logic [31:0] v);
        bus_xfer(`UCW_OFS_CTL, 1'b1, v);
        ctlM = ctl_next(ctlM, v);
    endtask
    task automatic chk_cfg();
        chk({sampleRateSelect, frameSizeSelect, muteSelect, muteWakeMethod, parityOn,
            parityOddSelect, txOn, rxOn, blockOn}, {ctlM[15], ctlM[12], ctlM[13],
            ctlM[11], ctlM[10], ctlM[9], ctlM[3], ctlM[2], ctlM[0]});
    endtask
    // one received character, flag expected only outside mute
    task automatic send_char(input logic [8:0] c);
        rxChar <= c;
        rxCharValid <= 1'b1;
        @(posedge clk);
        rxCharValid <= 1'b0;
        if (c[7:0] == matchVal && ctlM[0] && ctlM[2] && !ctlM[13]) matchM = 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ticks seen with the driver on, before start and after message end
    always @(posedge clk) begin
        if (startGo === 1'b1) goSeen = 1'b1;
        else if (lineDriverEnable === 1'b1 && !goSeen && sampleTick === 1'b1) leadCnt++;
        if (txMsgEnd === 1'b1) endSeen = 1'b1;
        else if (lineDriverEnable === 1'b1 && endSeen && sampleTick === 1'b1) tailCnt++;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        $display("[ERR] t=%0t watchdog seen=%h exp=%h", $time, 32'h0, 32'h1);
        end_sim();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {srst, hsel, hwrite, rxCharValid, kernelClkSlow, frameGo, matchM} = 7'h40;
        {haddr, hwdata, htrans, rxChar, flags, ctlM} = '0;
        rnd = 32'h0001498f;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        // reset value, full write, random writes with the lock, unmapped place
        rd_chk(`UCW_OFS_CTL, `UCW_CTL_RESET);
        chk(hresp, 1'b0);
        wr_ctl(32'hffffffff);
        rd_chk(`UCW_OFS_CTL, ctlM);
        chk_cfg();
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr_ctl(rnd);
            rd_chk(`UCW_OFS_CTL, ctlM);
            chk_cfg();
        end
        bus_xfer(12'h004, 1'b1, 32'hffffffff);
        rd_chk(12'h004, 32'h00000000);
        rd_chk(`UCW_OFS_CTL, ctlM);
        $display("register test done");
        // each enable alone against its own flag, the others and random flags
        for (int k = 0; k < 8; k++) begin
            wr_ctl(32'h00000003 | (32'h1 << irqPos[k]));
            for (int s = 0; s < 3; s++) begin
                rnd = lfsr(rnd);
                flags <= (s == 0) ? 8'h01 << k : (s == 1) ? ~(8'h01 << k) : rnd[7:0];
                kernelClkSlow <= rnd[8];
                repeat (3) @(posedge clk);
                chk(irqOut, irq_model(flags, ctlM));
                chk(wakeReq, irq_model(flags, ctlM) & ctlM[1] & ctlM[0] & kernelClkSlow);
            end
        end
        flags <= 8'h00;
        $display("interrupt test done");
        // character match: muted, mismatch, match, enable off, clear
        rnd = lfsr(rnd);
        matchVal = rnd[7:0];
        bus_xfer(`UCW_OFS_MATCH, 1'b1, {24'h000000, matchVal});
        wr_ctl(32'h00006005);
        send_char({rnd[8], matchVal});
        rd_chk(`UCW_OFS_STATUS, 32'h00000000);
        wr_ctl(32'h00004005);
        send_char({rnd[8], matchVal ^ 8'h01});
        rd_chk(`UCW_OFS_STATUS, 32'h00000000);
        send_char({rnd[8], matchVal});
        rd_chk(`UCW_OFS_STATUS, {29'h0, irq_model(8'h00, ctlM), 1'b0, matchM});
        wr_ctl(32'h00000005);
        repeat (2) @(posedge clk);
        chk(irqOut, 1'b0);
        bus_xfer(`UCW_OFS_STATUS, 1'b1, 32'h00000001);
        matchM = 1'b0;
        rd_chk(`UCW_OFS_STATUS, 32'h00000000);
        $display("match test done");
        // driver lead and tail in ticks; no special modes, so either rate is legal
        for (int i = 0; i < 3; i++) begin
            wr_ctl(32'h00000000);
            wr_ctl({6'h00, leadTab[i], tailTab[i], i[0], 15'h0009});
            {leadCnt, tailCnt, goSeen, endSeen} = '0;
            frameGo <= 1'b1;
            for (n = 0; n < 4000 && !(frameDone === 1'b1 && lineDriverEnable === 1'b0); n++)
                @(posedge clk);
            frameGo <= 1'b0;
            chk(n < 4000, 1'b1);
            chk(leadCnt, leadTab[i]);
            chk(tailCnt, tailTab[i]);
        end
        // transmitter switched off with the driver on
        wr_ctl(32'h00000000);
        wr_ctl(32'h03e00009);
        frameGo <= 1'b1;
        for (n = 0; n < 100 && lineDriverEnable !== 1'b1; n++) @(posedge clk);
        chk(lineDriverEnable, 1'b1);
        wr_ctl(32'h03e00001);
        repeat (2) @(posedge clk);
        chk(lineDriverEnable, 1'b0);
        frameGo <= 1'b0;
        $display("driver test done");
        end_sim();
    end
endmodule // test_uart_control_word_zero
`default_nettype wire

// [ucw_control_word_zero.sv]
// Purpose: control word zero register, interrupt gating, match and driver timing
// Assumes: AHB-Lite single word transfers, status flags come from the datapath
// Notes: zero wait state slave, always OKAY
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ucw_params.svh"
module ucw_control_word_zero
    import ucw_pkg::*;
#(
    parameter bit HAS_BLOCK_EXT = 1'b1 // 0 for the second instance
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // status flags from the datapath
    input wire logic blockEndFlag,
    input wire logic rxTimeoutFlag,
    input wire logic parityFaultFlag,
    input wire logic txEmptyFlag,
    input wire logic txDoneFlag,
    input wire logic rxReadyFlag,
    input wire logic overrunFlag,
    input wire logic idleLineFlag,
    // receive character stream
    input wire logic rxCharValid,
    input wire logic [8:0] rxChar,
    // clocking and power
    input wire logic sampleTick,
    input wire logic kernelClkSlow,
    // transmitter handshake
    input wire logic txFrameReq,
    input wire logic txMsgEnd,
    // configuration to the datapath
    output logic sampleRateSelect,
    output logic frameSizeSelect,
    output logic muteSelect,
    output logic muteWakeMethod,
    output logic parityOn,
    output logic parityOddSelect,
    output logic txOn,
    output logic rxOn,
    output logic blockOn,
    // line and interrupt
    output logic lineDriverEnable,
    output logic startGo,
    output logic irqOut,
    output logic wakeReq
);
    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam logic [31:0] VALID_MASK = HAS_BLOCK_EXT ? `UCW_VALID_FULL : `UCW_VALID_BASE;
    localparam logic [31:0] LOCK_MASK = `UCW_LOCK_MASK;

    // address decode helper
    function automatic logic isReg(input logic [11:0] a, input logic [11:0] ofs);
        isReg = (a[11:2] == ofs[11:2]);
    endfunction

    // ----------------------------------------
    // bus state
    // ----------------------------------------
    logic wrPend_r, wrPend_nxt; // write data phase pending
    logic [11:0] wrAddr_r, wrAddr_nxt; // address of pending write
    logic [31:0] rdData_r, rdData_nxt; // read data for the data phase
    logic addrTake; // address phase accepted
    logic wrCtl; // data phase write to control word
    logic wrStatus; // data phase write to status
    logic wrMatch; // data phase write to match value

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [31:0] ctl_r, ctl_nxt; // control word zero
    logic [7:0] match_r, match_nxt; // character match value
    logic matchFlag_r, matchFlag_nxt; // sticky character match flag
    logic irq_r, irq_nxt; // interrupt request flop
    logic wake_r, wake_nxt; // deep-sleep wake request flop
    logic matchHit; // received byte equals match value
    logic irqAny; // any enabled event present
    logic [31:0] lockedBits; // locked fields view
    logic deLine; // driver enable from sequencer
    logic deGo; // start release from sequencer

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // accept an address phase on a selected non-idle transfer
    assign addrTake = hsel && htrans[1] && hready;
    assign wrCtl = wrPend_r && isReg(wrAddr_r, `UCW_OFS_CTL);
    assign wrStatus = wrPend_r && isReg(wrAddr_r, `UCW_OFS_STATUS);
    assign wrMatch = wrPend_r && isReg(wrAddr_r, `UCW_OFS_MATCH);

    // next values of the bus pipeline and read mux
    always_comb begin
        wrPend_nxt = addrTake && hwrite;
        wrAddr_nxt = addrTake ? haddr[11:0] : wrAddr_r;
        rdData_nxt = 32'h00000000;
        if (addrTake && !hwrite) begin
            if (isReg(haddr[11:0], `UCW_OFS_CTL)) begin
                rdData_nxt = ctl_r; // reserved bits held at zero
            end else if (isReg(haddr[11:0], `UCW_OFS_STATUS)) begin
                rdData_nxt = {29'h00000000, irq_r, deLine, matchFlag_r};
            end else if (isReg(haddr[11:0], `UCW_OFS_MATCH)) begin
                rdData_nxt = {24'h000000, match_r};
            end else begin
                rdData_nxt = 32'h00000000; // unmapped reads zero
            end
        end
    end

    // register the bus pipeline
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 12'h000;
            rdData_r <= 32'h00000000;
        end else begin
            wrPend_r <= wrPend_nxt;
            wrAddr_r <= wrAddr_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    // ----------------------------------------
    // control word and match value
    // ----------------------------------------
    // write with format fields held while the block is on
    always_comb begin
        ctl_nxt = ctl_r;
        match_nxt = match_r;
        if (wrCtl) begin
            ctl_nxt = hwdata & VALID_MASK;
            if (ctl_r[`UCW_B_ON]) begin
                ctl_nxt = (ctl_nxt & ~LOCK_MASK) | (ctl_r & LOCK_MASK);
            end
        end
        if (wrMatch) begin
            match_nxt = hwdata[7:0];
        end
    end

    // register the control word
    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_r <= `UCW_CTL_RESET;
            match_r <= 8'h00;
        end else begin
            ctl_r <= ctl_nxt;
            match_r <= match_nxt;
        end
    end

    assign lockedBits = ctl_r & LOCK_MASK;

    // ----------------------------------------
    // character match
    // ----------------------------------------
    // whole byte compare in normal reception only, not while muted
    assign matchHit = rxCharValid && ctl_r[`UCW_B_ON] && ctl_r[`UCW_B_RXON]
        && !ctl_r[`UCW_B_MUTE] && (rxChar[7:0] == match_r);

    // sticky flag, write one to clear, a new hit beats the clear
    always_comb begin
        matchFlag_nxt = matchFlag_r;
        if (wrStatus && hwdata[0]) begin
            matchFlag_nxt = 1'b0;
        end
        if (matchHit) begin
            matchFlag_nxt = 1'b1;
        end
    end

    // ----------------------------------------
    // interrupt and wake
    // ----------------------------------------
    // each event gated by its enable, all ORed together
    always_comb begin
        irqAny = 1'b0;
        irqAny = irqAny || (blockEndFlag && ctl_r[`UCW_B_BLKEND]);
        irqAny = irqAny || (rxTimeoutFlag && ctl_r[`UCW_B_RXTO]);
        irqAny = irqAny || (matchFlag_r && ctl_r[`UCW_B_MATCHIE]);
        irqAny = irqAny || (parityFaultFlag && ctl_r[`UCW_B_PARIE]);
        irqAny = irqAny || (txEmptyFlag && ctl_r[`UCW_B_TXEIE]);
        irqAny = irqAny || (txDoneFlag && ctl_r[`UCW_B_TXDIE]);
        irqAny = irqAny || ((rxReadyFlag || overrunFlag) && ctl_r[`UCW_B_RXIE]);
        irqAny = irqAny || (idleLineFlag && ctl_r[`UCW_B_IDLE_IRQ_EN]);
        irq_nxt = irqAny;
        // wake only on the slow kernel clocks with the block running
        wake_nxt = irqAny && ctl_r[`UCW_B_WAKE] && ctl_r[`UCW_B_ON] && kernelClkSlow;
    end

    // register flag, interrupt and wake
    always_ff @(posedge clk) begin
        if (srst) begin
            matchFlag_r <= 1'b0;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            matchFlag_r <= matchFlag_nxt;
            irq_r <= irq_nxt;
            wake_r <= wake_nxt;
        end
    end

    // ----------------------------------------
    // driver enable sequencer
    // ----------------------------------------
    // lead and tail measured in sample ticks of the chosen rate
    ucw_driver_timer u_timer (
        .clk(clk),
        .srst(srst),
        .txOn(ctl_r[`UCW_B_TXON] && ctl_r[`UCW_B_ON]),
        .sampleTick(sampleTick),
        .leadTime(ctl_r[`UCW_F_LEAD_HI:`UCW_F_LEAD_LO]),
        .tailTime(ctl_r[`UCW_F_TAIL_HI:`UCW_F_TAIL_LO]),
        .txFrameReq(txFrameReq),
        .txMsgEnd(txMsgEnd),
        .lineDriverEnable(deLine),
        .startGo(deGo)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hreadyout = 1'b1; // zero wait states
    assign hrdata = rdData_r;
    assign hresp = 1'b0; // always OKAY
    assign sampleRateSelect = ctl_r[`UCW_B_SAMPLE];
    assign frameSizeSelect = ctl_r[`UCW_B_SIZE];
    assign muteSelect = ctl_r[`UCW_B_MUTE];
    assign muteWakeMethod = ctl_r[`UCW_B_WAKEM];
    assign parityOn = ctl_r[`UCW_B_PAR];
    assign parityOddSelect = ctl_r[`UCW_B_ODD];
    assign txOn = ctl_r[`UCW_B_TXON];
    assign rxOn = ctl_r[`UCW_B_RXON];
    assign blockOn = ctl_r[`UCW_B_ON];
    assign lineDriverEnable = deLine;
    assign startGo = deGo;
    assign irqOut = irq_r;
    assign wakeReq = wake_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_lock_hold: assert property (wrCtl && ctl_r[`UCW_B_ON]
        |=> lockedBits == $past(lockedBits))
        else $error("locked field changed while block on");
    a_open_write: assert property (wrCtl && !ctl_r[`UCW_B_ON]
        |=> ctl_r == ($past(hwdata) & VALID_MASK))
        else $error("control write not stored");
    a_match_set: assert property (matchHit |=> matchFlag_r)
        else $error("match flag not set on equal byte");
    a_match_irq: assert property (matchHit && ctl_r[`UCW_B_MATCHIE]
        |=> ##1 irq_r)
        else $error("match interrupt missing");
    a_block_end: assert property (blockEndFlag && ctl_r[`UCW_B_BLKEND] |=> irq_r)
        else $error("end of block interrupt missing");
    a_rx_irq: assert property ((rxReadyFlag || overrunFlag) && ctl_r[`UCW_B_RXIE]
        |=> irq_r)
        else $error("receive interrupt missing");
    a_irq_quiet: assert property (!irqAny |=> !irq_r)
        else $error("interrupt without an enabled event");
    a_tx_irq: assert property (((txEmptyFlag && ctl_r[`UCW_B_TXEIE])
        || (txDoneFlag && ctl_r[`UCW_B_TXDIE])) |=> irq_r)
        else $error("transmit interrupt missing");
    a_wake_gate: assert property (wake_r |-> $past(kernelClkSlow)
        && $past(ctl_r[`UCW_B_WAKE]))
        else $error("wake without permission or slow clock");
endmodule // ucw_control_word_zero
`default_nettype wire

// [ucw_driver_timer.sv]
// Purpose: driver enable lead and tail sequencer
// Assumes: sampleTick is one pulse per sample time
// Notes: a new frame during the tail keeps the driver on
`timescale 1ns/1ps
`default_nettype none
module ucw_driver_timer
    import ucw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic txOn,
    input wire logic sampleTick,
    input wire logic [4:0] leadTime,
    input wire logic [4:0] tailTime,
    // transmitter handshake
    input wire logic txFrameReq,
    input wire logic txMsgEnd,
    // outputs
    output logic lineDriverEnable,
    output logic startGo
);
    ucw_de_state_e state_r, state_nxt; // sequencer state
    logic [4:0] cnt_r, cnt_nxt; // sample ticks counted
    logic de_r, de_nxt; // driver enable flop
    logic go_r, go_nxt; // start bit may begin

    // next state of the sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        de_nxt = de_r;
        go_nxt = 1'b0;
        case (state_r)
            UCW_DE_IDLE: begin
                if (txOn && txFrameReq) begin
                    state_nxt = UCW_DE_LEAD;
                    cnt_nxt = 5'h00;
                    de_nxt = 1'b1;
                end
            end
            UCW_DE_LEAD: begin
                if (cnt_r == leadTime) begin
                    state_nxt = UCW_DE_ON;
                    go_nxt = 1'b1;
                end else if (sampleTick) begin
                    cnt_nxt = cnt_r + 5'h01;
                end
            end
            UCW_DE_ON: begin
                if (txMsgEnd) begin
                    state_nxt = UCW_DE_TAIL;
                    cnt_nxt = 5'h00;
                end
            end
            UCW_DE_TAIL: begin
                if (txFrameReq) begin
                    state_nxt = UCW_DE_ON;
                    go_nxt = 1'b1;
                end else if (cnt_r == tailTime) begin
                    state_nxt = UCW_DE_IDLE;
                    de_nxt = 1'b0;
                end else if (sampleTick) begin
                    cnt_nxt = cnt_r + 5'h01;
                end
            end
            default: begin
                state_nxt = UCW_DE_IDLE;
                de_nxt = 1'b0;
            end
        endcase
        if (!txOn) begin
            state_nxt = UCW_DE_IDLE;
            de_nxt = 1'b0;
            go_nxt = 1'b0;
        end
    end

    // register the sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= UCW_DE_IDLE;
            cnt_r <= 5'h00;
            de_r <= 1'b0;
            go_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            de_r <= de_nxt;
            go_r <= go_nxt;
        end
    end

    assign lineDriverEnable = de_r;
    assign startGo = go_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_leadDone;
        state_r == UCW_DE_LEAD && cnt_r == leadTime && txOn;
    endsequence
    sequence s_tailDone;
        state_r == UCW_DE_TAIL && cnt_r == tailTime && txOn && !txFrameReq;
    endsequence
    a_lead_go: assert property (s_leadDone |=> go_r && de_r)
        else $error("start not released after lead time");
    a_tail_off: assert property (s_tailDone |=> !de_r)
        else $error("driver not dropped after tail time");
    a_tick_count: assert property (state_r == UCW_DE_LEAD && cnt_r != leadTime
        && !sampleTick && txOn |=> $stable(cnt_r))
        else $error("lead count moved without a sample tick");
endmodule // ucw_driver_timer
`default_nettype wire

// [ucw_line_partner.sv]
// Purpose: far-side model, sample ticks and one transmit frame per command
// Assumes: frameGo stays high for the whole frame and drops between frames
// Notes: the end of the last stop bit never falls in a tick cycle
`timescale 1ns/1ps
`default_nettype none
module ucw_line_partner #(
    parameter int TICK_DIV = 8, // clocks per sample tick
    parameter int FRAME_TICKS = 4 // ticks of frame body
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bench command and status
    input wire logic frameGo,
    output logic frameDone,
    // block side
    input wire logic startGo,
    output logic sampleTick,
    output logic txFrameReq,
    output logic txMsgEnd
);
    int div; // tick divider
    int ticks; // ticks spent in frame body
    logic busy; // frame body on the line
    // tick generator and frame sequencer
    always @(posedge clk) begin
        if (srst) begin
            div <= 0;
            ticks <= 0;
            busy <= 1'b0;
            frameDone <= 1'b0;
            sampleTick <= 1'b0;
            txFrameReq <= 1'b0;
            txMsgEnd <= 1'b0;
        end else begin
            div <= (div == TICK_DIV - 1) ? 0 : div + 1;
            sampleTick <= (div == TICK_DIV - 1);
            txMsgEnd <= 1'b0;
            if (!frameGo) begin
                // frame withdrawn, request released
                txFrameReq <= 1'b0;
                busy <= 1'b0;
                frameDone <= 1'b0;
            end else if (!busy && !frameDone) begin
                // request held until start bit is let go, then dropped
                txFrameReq <= !startGo;
                busy <= startGo;
                ticks <= 0;
            end else if (busy) begin
                // frame body, end pulse placed away from the tick
                ticks <= ticks + int'(sampleTick);
                if (ticks >= FRAME_TICKS && div == 2) begin
                    txMsgEnd <= 1'b1;
                    busy <= 1'b0;
                    frameDone <= 1'b1;
                end
            end
        end
    end
endmodule // ucw_line_partner
`default_nettype wire

// [ucw_params.svh]
// Purpose: constants for the control word zero block
// Assumes: included by bare name, definitions only
// Notes: offsets are byte addresses on a 32-bit bus
//
// Behaviour
// - bit 27 gates end-of-block interrupt
// - bit 26 gates receiver timeout interrupt
// - bits 25:21 driver lead before start bit
// - bits 20:16 driver tail after last stop
// - lead and tail counted in sample ticks
// - bit 14 gates character match interrupt
// - bit 13 turns mute mode on
// - bit 11 picks idle or address wake
// - bit 10 parity on, bit 9 odd
// - bit 8 gates parity fault interrupt
// - bit 7 gates transmit empty interrupt
// - bit 6 gates transmit done interrupt
// - bit 5 gates receive ready or overrun
// - bit 4 gates idle line interrupt
// - bit 1 allows deep-sleep wake, slow clock
// - format fields locked while block enabled
// - received byte equal match value sets flag, outside mute only
// - enabled events ORed onto one line
`ifndef UCW_PARAMS_SVH
`define UCW_PARAMS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define UCW_OFS_CTL 12'h000
`define UCW_OFS_STATUS 12'h008
`define UCW_OFS_MATCH 12'h00c
`define UCW_CTL_RESET 32'h00000000
`define UCW_VALID_FULL 32'h0fffffff
`define UCW_VALID_BASE 32'h03ffffff
`define UCW_LOCK_MASK 32'h03ff9e00
// ----------------------------------------
// field positions
// ----------------------------------------
`define UCW_B_BLKEND 27
`define UCW_B_RXTO 26
`define UCW_F_LEAD_HI 25
`define UCW_F_LEAD_LO 21
`define UCW_F_TAIL_HI 20
`define UCW_F_TAIL_LO 16
`define UCW_B_SAMPLE 15
`define UCW_B_MATCHIE 14
`define UCW_B_MUTE 13
`define UCW_B_SIZE 12
`define UCW_B_WAKEM 11
`define UCW_B_PAR 10
`define UCW_B_ODD 9
`define UCW_B_PARIE 8
`define UCW_B_TXEIE 7
`define UCW_B_TXDIE 6
`define UCW_B_RXIE 5
`define UCW_B_IDLE_IRQ_EN 4
`define UCW_B_TXON 3
`define UCW_B_RXON 2
`define UCW_B_WAKE 1
`define UCW_B_ON 0
`endif

// [ucw_pkg.sv]
// Purpose: types shared by the control word zero block
// Assumes: nothing
// Notes: state codes are binary
package ucw_pkg;
    // driver enable sequencer states
    typedef enum logic [1:0] {
        UCW_DE_IDLE = 2'b00,
        UCW_DE_LEAD = 2'b01,
        UCW_DE_ON = 2'b10,
        UCW_DE_TAIL = 2'b11
    } ucw_de_state_e;
endpackage
